//--- verilog/eirq_top.sv
// External interrupt and transfer request controller with an Avalon-MM slave.
// Functional notes
// RQ1 - Exactly five request inputs are accepted.
// RQ2 - Bus receive line is one detector input.
// RQ3 - Each input has its own detect condition.
// RQ4 - High, low, rising or falling triggers selectable.
// RQ5 - Transfer mode sources use level signalling only.
// RQ6 - Enable bit gates each input's request.
// RQ7 - Cause flag holds until software or a serviced transfer clears it.
// RQ8 - Select bit zero gives a plain interrupt.
// RQ9 - Select one transfers, then interrupts after count.
// RQ10 - Five inputs share three interrupt vectors.
// RQ11 - Inputs pass a two-stage synchroniser first.
// RQ12 - Writing zero clears, one keeps, set wins.
`timescale 1ns/1ps
`include "eirq_cfg.svh"
module eirq_top (
	// Clock and reset.
	input wire logic clock,
	input wire logic rst_n,
	// Avalon-MM register slave.
	input wire logic [`EIRQ_AW-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// Request inputs from outside the chip.
	input wire logic can_rx,
	input wire logic ext_req_pin_a,
	input wire logic ext_req_pin_b,
	input wire logic ext_req_pin_c,
	input wire logic ext_req_pin_d,
	// Interrupt system, one bit per vector.
	output logic [2:0] irq_req,
	output logic [2:0] xfer_req,
	input wire logic [2:0] xfer_ack
);
	import eirq_pkg::*;

	eirq_top_st_t st;
	eirq_top_st_t nx;
	eirq_det_if dif();

	logic rw;
	logic acc;
	logic [7:0] hit8;
	logic [7:0] sw_clr;
	logic [7:0] hw_clr;
	logic [2:0] pend;

	// Cause bits that belong to each vector.
	function automatic logic [7:0] vec_mask(input int v);
		case (v)
			0: vec_mask = `EIRQ_VEC0_MASK; // RQ10
			1: vec_mask = `EIRQ_VEC1_MASK; // RQ10
			2: vec_mask = `EIRQ_VEC2_MASK; // RQ10
			default: vec_mask = 8'h00;
		endcase
	endfunction

	// Place the five detector channels on their register bit positions.
	function automatic logic [7:0] expand(input logic [4:0] c);
		expand = {c[4], c[3], c[2], c[1], 3'b000, c[0]} & `EIRQ_CH_MASK; // RQ1
	endfunction

	function automatic logic [31:0] ctrl_word(input logic ats, input logic [7:0] cnt);
		ctrl_word = '0;
		ctrl_word[`EIRQ_ATS_BIT] = ats;
		ctrl_word[`EIRQ_CNT_MSB:`EIRQ_CNT_LSB] = cnt;
	endfunction

	// Channel zero is the bus receive line so bus traffic can wake the chip.
	assign dif.raw = {ext_req_pin_d, ext_req_pin_c, ext_req_pin_b, ext_req_pin_a, can_rx}; // RQ2
	assign dif.cond = {st.level[15:8], st.level[1:0]}; // RQ3

	eirq_detect #(
		.CH(5)
	) u_detect (
		.clock(clock),
		.rst_n(rst_n),
		.dif(dif)
	);

	assign hit8 = expand(dif.hit);
	assign rw = avs_read | avs_write;
	assign acc = rw & ~st.waitreq;

	always_comb begin
		for (int v = 0; v < 3; v++) begin
			pend[v] = |(st.cause & st.enable & vec_mask(v)); // RQ6
		end
	end

	always_comb begin
		nx = st;
		sw_clr = 8'h00;
		hw_clr = 8'h00;
		// One wait cycle per access keeps the read mux off the bus path.
		nx.waitreq = ~(rw & st.waitreq);
		if (rw && st.waitreq) begin
			case (avs_address)
				`EIRQ_OFS_LEVEL: nx.rdata = {16'h0000, st.level};
				`EIRQ_OFS_CAUSE: nx.rdata = {24'h000000, st.cause};
				`EIRQ_OFS_ENABLE: nx.rdata = {24'h000000, st.enable};
				`EIRQ_OFS_CTRL0: nx.rdata = ctrl_word(st.ats[0], st.cnt[0]);
				`EIRQ_OFS_CTRL1: nx.rdata = ctrl_word(st.ats[1], st.cnt[1]);
				`EIRQ_OFS_CTRL2: nx.rdata = ctrl_word(st.ats[2], st.cnt[2]);
				default: nx.rdata = 32'h00000000;
			endcase
		end
		// Transfer sequencing per vector.
		for (int v = 0; v < 3; v++) begin
			case (st.xst[v])
				EIRQ_X_IDLE: begin
					if (st.ats[v] && pend[v] && (st.cnt[v] != 8'h00)) begin
						nx.xst[v] = EIRQ_X_REQ; // RQ9
						nx.xreq[v] = 1'b1;
					end
				end
				EIRQ_X_REQ: begin
					if (xfer_ack[v]) begin
						// Serviced sources are cleared so the next request is a new one.
						hw_clr = hw_clr | vec_mask(v); // RQ9
						nx.cnt[v] = st.cnt[v] - 8'h01; // RQ9
						nx.xst[v] = EIRQ_X_IDLE;
						nx.xreq[v] = 1'b0;
					end
				end
				default: begin
					nx.xst[v] = EIRQ_X_IDLE;
					nx.xreq[v] = 1'b0;
				end
			endcase
			// A level source still active after its transfer reasserts at once,
			// which is why transfer mode expects level signalling.
			nx.irq[v] = pend[v] && (!st.ats[v] || ((st.cnt[v] == 8'h00) && (st.xst[v] == EIRQ_X_IDLE))); // RQ8 RQ9 RQ5
		end
		if (acc && avs_write) begin
			case (avs_address)
				`EIRQ_OFS_LEVEL: nx.level = avs_writedata[15:0]; // RQ3
				`EIRQ_OFS_CAUSE: sw_clr = ~avs_writedata[7:0]; // RQ12
				`EIRQ_OFS_ENABLE: nx.enable = avs_writedata[7:0] & `EIRQ_CH_MASK; // RQ6
				`EIRQ_OFS_CTRL0: begin
					nx.ats[0] = avs_writedata[`EIRQ_ATS_BIT];
					nx.cnt[0] = avs_writedata[`EIRQ_CNT_MSB:`EIRQ_CNT_LSB];
				end
				`EIRQ_OFS_CTRL1: begin
					nx.ats[1] = avs_writedata[`EIRQ_ATS_BIT];
					nx.cnt[1] = avs_writedata[`EIRQ_CNT_MSB:`EIRQ_CNT_LSB];
				end
				`EIRQ_OFS_CTRL2: begin
					nx.ats[2] = avs_writedata[`EIRQ_ATS_BIT];
					nx.cnt[2] = avs_writedata[`EIRQ_CNT_MSB:`EIRQ_CNT_LSB];
				end
				default: nx.level = st.level;
			endcase
		end
		// A new detection outranks any clear in the same cycle.
		nx.cause = ((st.cause & ~sw_clr & ~hw_clr) | hit8) & `EIRQ_CH_MASK; // RQ7 RQ12
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			st.waitreq <= 1'b1;
			st.rdata <= 32'h00000000;
			st.level <= `EIRQ_RST_LEVEL;
			st.cause <= `EIRQ_RST_CAUSE;
			st.enable <= `EIRQ_RST_ENABLE;
			st.ats <= 3'h0;
			st.cnt <= {`EIRQ_RST_CNT, `EIRQ_RST_CNT, `EIRQ_RST_CNT};
			st.xst <= {EIRQ_X_IDLE, EIRQ_X_IDLE, EIRQ_X_IDLE};
			st.xreq <= 3'h0;
			st.irq <= 3'h0;
		end else begin
			st <= nx;
		end
	end

	assign avs_readdata = st.rdata;
	assign avs_waitrequest = st.waitreq;
	assign irq_req = st.irq;
	assign xfer_req = st.xreq;

	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);

	chk_reserved_bits_zero: assert property ((st.cause & ~`EIRQ_CH_MASK) == 8'h00) // RQ1
		else $error("cause flag set on a channel that does not exist");
	chk_flag_held: assert property (st.cause[4] && !(acc && avs_write && (avs_address == `EIRQ_OFS_CAUSE))
		&& !(st.xst[1] == EIRQ_X_REQ && xfer_ack[1]) |=> st.cause[4]) // RQ7
		else $error("cause flag dropped without a clear");
	chk_set_wins: assert property (dif.hit[0] |=> st.cause[0]) // RQ12
		else $error("detected event lost against a clear");
	chk_write_one_keeps: assert property (st.cause[7] && acc && avs_write && (avs_address == `EIRQ_OFS_CAUSE)
		&& avs_writedata[7] && !(st.xst[2] == EIRQ_X_REQ && xfer_ack[2]) |=> st.cause[7]) // RQ12
		else $error("writing one cleared a cause flag");
	chk_irq_gated: assert property (irq_req[1] |-> $past(|(st.cause & st.enable & `EIRQ_VEC1_MASK))) // RQ6
		else $error("interrupt raised without an enabled cause");
	chk_direct_irq: assert property (!st.ats[0] && pend[0] |=> irq_req[0]) // RQ8
		else $error("plain interrupt not raised for an enabled cause");
	chk_xfer_first: assert property (st.ats[0] && (st.cnt[0] != 8'h00) |-> !irq_req[0] || $past(st.cnt[0] == 8'h00)
		|| $past(!st.ats[0])) // RQ9
		else $error("handler entered before the transfer count ran out");
	chk_cnt_step: assert property (xfer_req[0] && xfer_ack[0] && !(acc && avs_write)
		|=> st.cnt[0] == $past(st.cnt[0]) - 8'h01) // RQ9
		else $error("transfer count did not step by one");
	chk_wait_once: assert property (rw && avs_waitrequest |=> !avs_waitrequest)
		else $error("bus answer did not follow after one wait cycle");
endmodule

//--- verilog/eirq_cfg.svh
// Constants for the external interrupt and transfer request block.
`ifndef EIRQ_CFG_SVH
`define EIRQ_CFG_SVH
`define EIRQ_AW 5
`define EIRQ_OFS_LEVEL 5'h00
`define EIRQ_OFS_CAUSE 5'h04
`define EIRQ_OFS_ENABLE 5'h08
`define EIRQ_OFS_CTRL0 5'h0C
`define EIRQ_OFS_CTRL1 5'h10
`define EIRQ_OFS_CTRL2 5'h14
`define EIRQ_RST_LEVEL 16'h0000
`define EIRQ_RST_CAUSE 8'h00
`define EIRQ_RST_ENABLE 8'h00
`define EIRQ_RST_CNT 8'h00
`define EIRQ_CH_MASK 8'hF1
`define EIRQ_VEC0_MASK 8'h01
`define EIRQ_VEC1_MASK 8'h30
`define EIRQ_VEC2_MASK 8'hC0
`define EIRQ_VEC0_NUM 8'h0F
`define EIRQ_VEC1_NUM 8'h18
`define EIRQ_VEC2_NUM 8'h1B
`define EIRQ_ATS_BIT 0
`define EIRQ_CNT_LSB 8
`define EIRQ_CNT_MSB 15
`endif

//--- verilog/eirq_pkg.sv
// Types shared by the external interrupt and transfer request block.
package eirq_pkg;
	typedef enum logic [1:0] {
		EIRQ_COND_LOW = 2'b00,
		EIRQ_COND_HIGH = 2'b01,
		EIRQ_COND_RISE = 2'b10,
		EIRQ_COND_FALL = 2'b11
	} eirq_cond_t;

	typedef enum logic [1:0] {
		EIRQ_X_IDLE = 2'b00,
		EIRQ_X_REQ = 2'b01
	} eirq_xst_t;

	typedef struct packed {
		logic [4:0] sync1;
		logic [4:0] sync2;
		logic [4:0] prev;
	} eirq_det_st_t;

	typedef struct packed {
		logic waitreq;
		logic [31:0] rdata;
		logic [15:0] level;
		logic [7:0] cause;
		logic [7:0] enable;
		logic [2:0] ats;
		logic [2:0][7:0] cnt;
		eirq_xst_t [2:0] xst;
		logic [2:0] xreq;
		logic [2:0] irq;
	} eirq_top_st_t;
endpackage

//--- verilog/eirq_det_if.sv
// Carrier between the register logic and the input detector.
`timescale 1ns/1ps
interface eirq_det_if;
	logic [4:0] raw;
	logic [9:0] cond;
	logic [4:0] hit;
	modport src(output raw, output cond, input hit);
	modport det(input raw, input cond, output hit);
endinterface

//--- verilog/eirq_detect.sv
// Input synchroniser and level or edge detector for the five request inputs.
`timescale 1ns/1ps
`include "eirq_cfg.svh"
module eirq_detect #(
	parameter int CH = 5
) (
	// Clock and reset.
	input wire logic clock,
	input wire logic rst_n,
	// Detector side of the carrier.
	eirq_det_if.det dif
);
	import eirq_pkg::*;

	eirq_det_st_t st;
	eirq_det_st_t nx;

	initial begin
		if (CH != 5) begin
			$error("eirq_detect serves exactly five inputs");
		end
	end

	always_comb begin
		nx = st;
		nx.sync1 = dif.raw;
		nx.sync2 = st.sync1; // RQ11
		nx.prev = st.sync2;
	end

	// The stages reset to the idle high level of the request lines. Reset to zero would
	// look like a low level on every input and flag all of them at release. A line held
	// low through reset shows one falling edge after release.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			st <= '1;
		end else begin
			st <= nx;
		end
	end

	// Only the second stage and its delayed copy are looked at.
	always_comb begin
		for (int k = 0; k < 5; k++) begin
			case (eirq_cond_t'(dif.cond[2*k +: 2]))
				EIRQ_COND_LOW: dif.hit[k] = ~st.sync2[k]; // RQ4
				EIRQ_COND_HIGH: dif.hit[k] = st.sync2[k]; // RQ4
				EIRQ_COND_RISE: dif.hit[k] = st.sync2[k] & ~st.prev[k]; // RQ4
				EIRQ_COND_FALL: dif.hit[k] = ~st.sync2[k] & st.prev[k]; // RQ4
				default: dif.hit[k] = 1'b0;
			endcase
		end
	end

	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);

	chk_sync_two_stage: assert property (st.sync2 == $past(dif.raw, 2)) // RQ11
		else $error("input reaches the detector after other than two stages");
	chk_rise_edge_only: assert property ((dif.cond[1:0] == EIRQ_COND_RISE) && dif.hit[0]
		|-> st.sync2[0] && !$past(st.sync2[0])) // RQ4
		else $error("rising condition fired without a rising edge");
	chk_low_level_hit: assert property ((dif.cond[3:2] == EIRQ_COND_LOW) |-> dif.hit[1] == !st.sync2[1]) // RQ4
		else $error("low level condition does not follow the input");
endmodule

//--- dv/eirq_peer.sv
// Model of the outside devices that drive the request pins and serve transfers.
`timescale 1ns/1ps
module eirq_peer (
	// Clock and reset.
	input wire logic clock,
	input wire logic rst_n,
	// Pin levels asked for by the bench.
	input wire logic [4:0] pin_cmd,
	output logic [4:0] pins,
	// Transfer handshake.
	input wire logic [2:0] xfer_req,
	output logic [2:0] xfer_ack
);
	logic [2:0][1:0] wt;
	// Transfer sources signal by level only, so the pins simply follow the bench.
	assign pins = pin_cmd;
	// Each transfer is answered slowly, after a few waiting cycles, to stress the hold of the request.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			wt <= '0;
			xfer_ack <= '0;
		end else begin
			for (int v = 0; v < 3; v++) begin
				xfer_ack[v] <= xfer_req[v] && !xfer_ack[v] && wt[v] == 2'h3;
				wt[v] <= (xfer_req[v] && !xfer_ack[v] && wt[v] != 2'h3) ? wt[v] + 2'h1 : 2'h0;
			end
		end
	end
endmodule

//--- dv/eirq_top_tb.sv
// Self-checking bench for the external request controller.
`timescale 1ns/1ps
`include "eirq_cfg.svh"
module eirq_top_tb;
	import eirq_pkg::*;
	typedef struct {int src; eirq_cond_t cond; logic idle;} eirq_row_t;
	logic clock, rst_n, rd, wr, wq;
	logic [4:0] adr, pc, pins;
	logic [31:0] wd, rdt, q;
	logic [2:0] irq, xr, xa;
	int n_fail, num_checks, nack, b, v, i;
	eirq_row_t rows [7];
	eirq_top DUT (.clock(clock), .rst_n(rst_n), .avs_address(adr), .avs_read(rd), .avs_write(wr),
		.avs_writedata(wd), .avs_readdata(rdt), .avs_waitrequest(wq), .can_rx(pins[0]),
		.ext_req_pin_a(pins[1]), .ext_req_pin_b(pins[2]), .ext_req_pin_c(pins[3]),
		.ext_req_pin_d(pins[4]), .irq_req(irq), .xfer_req(xr), .xfer_ack(xa));
	eirq_peer peer (.clock(clock), .rst_n(rst_n), .pin_cmd(pc), .pins(pins), .xfer_req(xr), .xfer_ack(xa));
	initial begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end
	task stop_test;
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	// The request is held until waitrequest is seen low at a rising edge.
	task bus(input logic w, input logic [4:0] a, input logic [31:0] d);
		int k;
		@(posedge clock);
		adr <= a;
		wr <= w;
		rd <= !w;
		wd <= d;
		for (k = 0; k < 20; k++) begin
			@(posedge clock);
			if (wq === 1'b0) break;
		end
		if (k == 20) begin
			n_fail++;
			stop_test();
		end
		q = rdt;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask
	task cyc(input int n);
		repeat (n) @(posedge clock);
	endtask
	function automatic logic [4:0] pv(int s, logic val);
		pv = 5'h1F;
		pv[s] = val;
	endfunction
	initial begin
		rst_n = 1'b0;
		rd = 1'b0;
		wr = 1'b0;
		adr = 5'h00;
		wd = 32'h0;
		pc = 5'h1F;
		n_fail = 0;
		num_checks = 0;
		rows = '{'{0, EIRQ_COND_HIGH, 1'b0}, '{1, EIRQ_COND_LOW, 1'b1}, '{2, EIRQ_COND_RISE, 1'b0},
			'{3, EIRQ_COND_FALL, 1'b1}, '{4, EIRQ_COND_HIGH, 1'b0}, '{0, EIRQ_COND_FALL, 1'b1},
			'{1, EIRQ_COND_RISE, 1'b0}};
		cyc(3);
		rst_n <= 1'b1;
		for (i = 0; i < 5; i++) begin
			bus(1'b0, 5'(i * 4), 32'h0);
			chk(q, 32'h0);
		end
		$display("reset values done");
		for (int r = 0; r < 7; r++) begin
			b = rows[r].src == 0 ? 0 : rows[r].src + 3;
			v = rows[r].src == 0 ? 0 : (rows[r].src < 3 ? 1 : 2);
			pc <= pv(rows[r].src, rows[r].idle);
			bus(1'b1, `EIRQ_OFS_LEVEL, 32'(rows[r].cond) << (2 * b));
			bus(1'b1, `EIRQ_OFS_ENABLE, 32'h1 << b);
			cyc(5);
			bus(1'b1, `EIRQ_OFS_CAUSE, 32'h0);
			bus(1'b0, `EIRQ_OFS_CAUSE, 32'h0);
			chk(q, 32'h0);
			pc <= pv(rows[r].src, !rows[r].idle);
			cyc(6);
			bus(1'b0, `EIRQ_OFS_CAUSE, 32'h0);
			chk(q, 32'h1 << b);
			chk({29'h0, irq}, 32'h1 << v);
			chk({29'h0, xr}, 32'h0);
			pc <= pv(rows[r].src, rows[r].idle);
			cyc(5);
			bus(1'b1, `EIRQ_OFS_CAUSE, 32'hFF);
			bus(1'b0, `EIRQ_OFS_CAUSE, 32'h0);
			chk(q, 32'h1 << b);
			bus(1'b1, `EIRQ_OFS_CAUSE, 32'h0);
			bus(1'b0, `EIRQ_OFS_CAUSE, 32'h0);
			chk(q, 32'h0);
			$display("row %0d done", r);
		end
		// A request that is flagged while disabled must reach the processor once enabled.
		bus(1'b1, `EIRQ_OFS_LEVEL, 32'h400);
		bus(1'b1, `EIRQ_OFS_ENABLE, 32'h0);
		pc <= pv(2, 1'b1);
		cyc(6);
		bus(1'b1, `EIRQ_OFS_CAUSE, 32'h0);
		bus(1'b0, `EIRQ_OFS_CAUSE, 32'h0);
		chk(q, 32'h20);
		chk({29'h0, irq}, 32'h0);
		bus(1'b1, `EIRQ_OFS_ENABLE, 32'h20);
		cyc(3);
		chk({29'h0, irq}, 32'h2);
		pc <= pv(2, 1'b0);
		bus(1'b1, `EIRQ_OFS_ENABLE, 32'hFF);
		bus(1'b0, `EIRQ_OFS_ENABLE, 32'h0);
		chk(q, 32'hF1);
		bus(1'b0, 5'h1C, 32'h0);
		chk(q, 32'h0);
		$display("enable test done");
		// The source stays quiet and disabled until the transfer count is armed.
		pc <= pv(0, 1'b0);
		bus(1'b1, `EIRQ_OFS_ENABLE, 32'h0);
		bus(1'b1, `EIRQ_OFS_LEVEL, 32'h1);
		bus(1'b1, `EIRQ_OFS_CTRL0, 32'h201);
		bus(1'b1, `EIRQ_OFS_CAUSE, 32'h0);
		bus(1'b1, `EIRQ_OFS_ENABLE, 32'h1);
		chk({29'h0, xr}, 32'h0);
		nack = 0;
		pc <= pv(0, 1'b1);
		for (i = 0; i < 200; i++) begin
			@(negedge clock);
			if (xa[0] === 1'b1) nack++;
			if (irq[0] === 1'b1) break;
		end
		if (i == 200) begin
			n_fail++;
			stop_test();
		end
		chk(32'(nack), 32'h2);
		bus(1'b0, `EIRQ_OFS_CTRL0, 32'h0);
		chk(q, 32'h1);
		$display("transfer test done");
		rst_n <= 1'b0;
		cyc(2);
		chk({26'h0, irq, xr}, 32'h0);
		chk({31'h0, wq}, 32'h1);
		chk(rdt, 32'h0);
		rst_n <= 1'b1;
		bus(1'b0, `EIRQ_OFS_CAUSE, 32'h0);
		chk(q, 32'h0);
		$display("reset test done");
		stop_test();
	end
endmodule
